//--- logic/amp_i2c_params.svh
`ifndef AMP_I2C_PARAMS_SVH
`define AMP_I2C_PARAMS_SVH

// Serial address: fixed upper bits, then two selectable bits, then R/W
`define ADDR_FIXED        5'h1b
`define ADDR_SEL_PRIMARY  2'h0

// Register indices of the amplifier
`define REG_FAULT_GLOBAL  8'h00
`define REG_FAULT_CHAN    8'h01
`define REG_DIAG_CH12     8'h02
`define REG_DIAG_CH34     8'h03
`define REG_TEMP_VOLT     8'h04
`define REG_HIGHZ_LL      8'h05
`define REG_MUTE_PLAY     8'h06
`define REG_DIAG_STATUS   8'h07
`define REG_GAIN          8'h08
`define REG_OVERCURRENT   8'h09
`define REG_FREQ_CLIP     8'h0a
`define REG_DIAG_MASTER   8'h0b
`define REG_OUT_STATE_A   8'h0c
`define REG_OUT_STATE_B   8'h0d
`define REG_UNUSED_A      8'h0e
`define REG_UNUSED_B      8'h0f
`define REG_DC_THRESH     8'h10
`define REG_THERMAL       8'h13

// Field positions and reset values
`define FG_ANY_OC         2
`define FG_ANY_DC         1
`define FAULT_RESET       8'h00
`define CTRL_RESET        8'h00
`define UNMAPPED_READ     8'h00

// Controller APB map (byte addresses)
`define APB_CMD           8'h00
`define APB_WDATA         8'h04
`define APB_RDATA         8'h08
`define APB_STATUS        8'h0c
`define APB_MASK          8'h10
`define APB_CONFIG        8'h14
`define CMD_LEN_LSB       8
`define CMD_READ_BIT      12
`define CMD_GO_BIT        16
`define CMD_BUSY_BIT      31
`define ST_DONE_BIT       0
`define ST_NACK_BIT       1

// Serial clock timing
`define MCLK_NS           8
`define SCL_QUARTER_NS    625
`define SCL_QUARTER_CYC   ((`SCL_QUARTER_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

//--- logic/amp_i2c_pkg.sv
package amp_i2c_pkg;
	typedef enum logic [3:0] {
		T_IDLE, T_ADDR, T_AACK, T_INDEX, T_IACK,
		T_WDATA, T_WACK, T_RDATA, T_RACK, T_IGNORE
	} tgt_state_e;
	typedef enum logic [2:0] {
		C_IDLE, C_START, C_SEND, C_GETACK, C_RECV, C_PUTACK, C_STOP
	} ctl_state_e;
	typedef enum logic [1:0] {
		K_ADDRW, K_INDEX, K_WDATA, K_ADDRR
	} byte_kind_e;
endpackage

//--- logic/amp_i2c_if.sv
`timescale 1ns/1ns
interface amp_i2c_if;
	logic ctl_scl_out;
	logic ctl_scl_oe;
	logic ctl_sda_out;
	logic ctl_sda_oe;
	logic tgt_sda_out;
	logic tgt_sda_oe;
	logic scl;
	logic sda;

	// Open drain with pull-up: a released line reads high
	assign scl = ctl_scl_oe ? ctl_scl_out : 1'b1;
	assign sda = (ctl_sda_oe ? ctl_sda_out : 1'b1)
		& (tgt_sda_oe ? tgt_sda_out : 1'b1);

	modport controller(
		output ctl_scl_out, ctl_scl_oe, ctl_sda_out, ctl_sda_oe,
		input  scl, sda
	);
	modport target(
		output tgt_sda_out, tgt_sda_oe,
		input  scl, sda
	);
endinterface

//--- logic/amp_i2c_target.sv
`timescale 1ns/1ns
`include "amp_i2c_params.svh"
// Summary of operation
// - Write starts: start, address, direction zero
// - Acknowledge matching address, then index byte
// - Data byte stored at index, acked, stop
// - Every written byte acked, index plus one
// - Read: write index, repeated start, direction one
// - After read address ack, send indexed byte
// - Controller ends single read with nack, stop
// - Multi-byte read acked, index advances each
// - Address byte: 11011, two select bits, R/W
// - Select zero is oscillator primary, others follow
// - Indices 0x00-0x03 read-only latched faults
// - Indices 0x04-0x07, 0x13 read-only live status
// - Indices 0x08-0x0D, 0x10 read-write controls
// - Global fault bits: supply and thermal flags
// - Global bit 2 any overcurrent, 1 any DC
// - Channel fault: DC offset high, overcurrent low
// - Standby clears registers and releases bus
module amp_i2c_target (
	input  wire logic        mclk,              // System clock
	input  wire logic        rst,               // Async reset, high
	input  wire logic        standby_n,         // Standby pin, low
	input  wire logic [1:0]  addr_sel,          // Address select pins
	amp_i2c_if.target        bus,               // Serial bus
	input  wire logic [7:0]  global_events,     // Supply/thermal events
	input  wire logic [3:0]  dc_offset_events,  // Per channel DC
	input  wire logic [3:0]  overcurrent_events, // Per channel OC
	input  wire logic [15:0] load_diag_events,  // Load diagnostics
	input  wire logic [7:0]  temp_voltage_status,   // Live 0x04
	input  wire logic [7:0]  highz_lowlow_status,   // Live 0x05
	input  wire logic [7:0]  mute_play_status,      // Live 0x06
	input  wire logic [7:0]  load_diag_status,      // Live 0x07
	input  wire logic [7:0]  thermal_shutdown_foldback_status, // 0x13
	output logic      [7:0]  gain_select_ctrl,      // Control 0x08
	output logic      [7:0]  overcurrent_ctrl,      // Control 0x09
	output logic      [7:0]  switch_freq_clip_ctrl, // Control 0x0a
	output logic      [7:0]  diag_master_mode_ctrl, // Control 0x0b
	output logic      [7:0]  output_state_ctrl_a,   // Control 0x0c
	output logic      [7:0]  output_state_ctrl_b,   // Control 0x0d
	output logic      [7:0]  dc_detect_threshold_ctrl, // Control 0x10
	output logic             oscillator_primary_role   // Select is zero
);
	import amp_i2c_pkg::*;

	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	logic [1:0]  stby_s;
	logic [1:0]  asel_s0;
	logic [1:0]  asel_s1;
	logic [1:0]  asel_q;
	logic        standby;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	logic        sda_now;
	tgt_state_e  state;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  tx;
	logic [7:0]  index;
	logic        rw;
	logic        host_ack;
	logic        sda_oe;
	logic        wr_en;
	logic [7:0]  wr_idx;
	logic [7:0]  wr_data;
	logic [7:0]  rd_byte;
	logic [7:0]  latched_fault_global;
	logic [7:0]  latched_fault_per_channel;
	logic [7:0]  load_diag_ch12;
	logic [7:0]  load_diag_ch34;

	// Pins cross two flops; the third stage only serves edge detection
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_s   <= 3'h7;
			sda_s   <= 3'h7;
			stby_s  <= 2'h0;
			asel_s0 <= 2'h0;
			asel_s1 <= 2'h0;
		end else begin
			scl_s   <= {scl_s[1:0], bus.scl};
			sda_s   <= {sda_s[1:0], bus.sda};
			stby_s  <= {stby_s[0], standby_n};
			asel_s0 <= addr_sel;
			asel_s1 <= asel_s0;
		end
	end

	assign standby    = !stby_s[1];
	assign sda_now    = sda_s[1];
	assign scl_rise   = scl_s[1] & !scl_s[2];
	assign scl_fall   = !scl_s[1] & scl_s[2];
	assign start_cond = scl_s[1] & scl_s[2] & !sda_s[1] & sda_s[2];
	assign stop_cond  = scl_s[1] & scl_s[2] & sda_s[1] & !sda_s[2];

	// Straps are resampled only between transfers, never mid-frame
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			asel_q                  <= 2'h0;
			oscillator_primary_role <= 1'b0;
		end else begin
			if (state == T_IDLE)
				asel_q <= asel_s1;
			oscillator_primary_role <= (asel_q == `ADDR_SEL_PRIMARY);
		end
	end

	// Latched faults hold until reset or standby
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latched_fault_global      <= `FAULT_RESET;
			latched_fault_per_channel <= `FAULT_RESET;
			load_diag_ch12            <= `FAULT_RESET;
			load_diag_ch34            <= `FAULT_RESET;
		end else if (standby) begin
			latched_fault_global      <= `FAULT_RESET;
			latched_fault_per_channel <= `FAULT_RESET;
			load_diag_ch12            <= `FAULT_RESET;
			load_diag_ch34            <= `FAULT_RESET;
		end else begin
			latched_fault_global <= latched_fault_global | {
				global_events[7:3],
				|overcurrent_events,
				|dc_offset_events,
				global_events[0]};
			latched_fault_per_channel <= latched_fault_per_channel
				| {dc_offset_events, overcurrent_events};
			load_diag_ch12 <= load_diag_ch12 | load_diag_events[7:0];
			load_diag_ch34 <= load_diag_ch34 | load_diag_events[15:8];
		end
	end

	always_comb begin
		unique case (index)
			`REG_FAULT_GLOBAL: rd_byte = latched_fault_global;
			`REG_FAULT_CHAN:   rd_byte = latched_fault_per_channel;
			`REG_DIAG_CH12:    rd_byte = load_diag_ch12;
			`REG_DIAG_CH34:    rd_byte = load_diag_ch34;
			`REG_TEMP_VOLT:    rd_byte = temp_voltage_status;
			`REG_HIGHZ_LL:     rd_byte = highz_lowlow_status;
			`REG_MUTE_PLAY:    rd_byte = mute_play_status;
			`REG_DIAG_STATUS:  rd_byte = load_diag_status;
			`REG_THERMAL:      rd_byte = thermal_shutdown_foldback_status;
			`REG_GAIN:         rd_byte = gain_select_ctrl;
			`REG_OVERCURRENT:  rd_byte = overcurrent_ctrl;
			`REG_FREQ_CLIP:    rd_byte = switch_freq_clip_ctrl;
			`REG_DIAG_MASTER:  rd_byte = diag_master_mode_ctrl;
			`REG_OUT_STATE_A:  rd_byte = output_state_ctrl_a;
			`REG_OUT_STATE_B:  rd_byte = output_state_ctrl_b;
			`REG_DC_THRESH:    rd_byte = dc_detect_threshold_ctrl;
			default:           rd_byte = `UNMAPPED_READ;
		endcase
	end

	// Serial protocol; sda changes only after scl is seen low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state    <= T_IDLE;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			tx       <= 8'h00;
			index    <= 8'h00;
			rw       <= 1'b0;
			host_ack <= 1'b0;
			sda_oe   <= 1'b0;
			wr_en    <= 1'b0;
			wr_idx   <= 8'h00;
			wr_data  <= 8'h00;
		end else if (standby) begin
			state  <= T_IDLE;
			index  <= 8'h00;
			sda_oe <= 1'b0;
			wr_en  <= 1'b0;
		end else begin
			wr_en <= 1'b0;
			if (start_cond) begin
				// Repeated start keeps the index for the read that follows
				state  <= T_ADDR;
				bitcnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state  <= T_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				unique case (state)
					T_ADDR, T_INDEX, T_WDATA: begin
						shreg  <= {shreg[6:0], sda_now};
						bitcnt <= bitcnt + 4'h1;
					end
					T_RDATA: bitcnt <= bitcnt + 4'h1;
					T_RACK: host_ack <= !sda_now;
					T_IDLE, T_AACK, T_IACK, T_WACK, T_IGNORE: ;
				endcase
			end else if (scl_fall) begin
				unique case (state)
					T_ADDR: if (bitcnt == 4'h8) begin
						if (shreg[7:1] == {`ADDR_FIXED, asel_q}) begin
							rw     <= shreg[0];
							sda_oe <= 1'b1;
							state  <= T_AACK;
						end else begin
							state <= T_IGNORE;
						end
					end
					T_INDEX: if (bitcnt == 4'h8) begin
						index  <= shreg;
						sda_oe <= 1'b1;
						state  <= T_IACK;
					end
					T_WDATA: if (bitcnt == 4'h8) begin
						wr_en   <= 1'b1;
						wr_idx  <= index;
						wr_data <= shreg;
						index   <= index + 8'h01;
						sda_oe  <= 1'b1;
						state   <= T_WACK;
					end
					T_AACK: begin
						bitcnt <= 4'h0;
						if (rw) begin
							tx     <= rd_byte;
							sda_oe <= !rd_byte[7];
							index  <= index + 8'h01;
							state  <= T_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state  <= T_INDEX;
						end
					end
					T_IACK, T_WACK: begin
						bitcnt <= 4'h0;
						sda_oe <= 1'b0;
						state  <= T_WDATA;
					end
					T_RDATA: if (bitcnt == 4'h8) begin
						sda_oe <= 1'b0;
						state  <= T_RACK;
					end else begin
						tx     <= {tx[6:0], 1'b1};
						sda_oe <= !tx[6];
					end
					T_RACK: begin
						bitcnt <= 4'h0;
						if (host_ack) begin
							tx     <= rd_byte;
							sda_oe <= !rd_byte[7];
							index  <= index + 8'h01;
							state  <= T_RDATA;
						end else begin
							// Nack ends the read; wait for stop
							state <= T_IGNORE;
						end
					end
					T_IDLE, T_IGNORE: ;
				endcase
			end
		end
	end

	// Writes to read-only or unused indices are acked and dropped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gain_select_ctrl         <= `CTRL_RESET;
			overcurrent_ctrl         <= `CTRL_RESET;
			switch_freq_clip_ctrl    <= `CTRL_RESET;
			diag_master_mode_ctrl    <= `CTRL_RESET;
			output_state_ctrl_a      <= `CTRL_RESET;
			output_state_ctrl_b      <= `CTRL_RESET;
			dc_detect_threshold_ctrl <= `CTRL_RESET;
		end else if (standby) begin
			gain_select_ctrl         <= `CTRL_RESET;
			overcurrent_ctrl         <= `CTRL_RESET;
			switch_freq_clip_ctrl    <= `CTRL_RESET;
			diag_master_mode_ctrl    <= `CTRL_RESET;
			output_state_ctrl_a      <= `CTRL_RESET;
			output_state_ctrl_b      <= `CTRL_RESET;
			dc_detect_threshold_ctrl <= `CTRL_RESET;
		end else if (wr_en) begin
			unique case (wr_idx)
				`REG_GAIN:        gain_select_ctrl <= wr_data;
				`REG_OVERCURRENT: overcurrent_ctrl <= wr_data;
				`REG_FREQ_CLIP:   switch_freq_clip_ctrl <= wr_data;
				`REG_DIAG_MASTER: diag_master_mode_ctrl <= wr_data;
				`REG_OUT_STATE_A: output_state_ctrl_a <= wr_data;
				`REG_OUT_STATE_B: output_state_ctrl_b <= wr_data;
				`REG_DC_THRESH:   dc_detect_threshold_ctrl <= wr_data;
				default: ;
			endcase
		end
	end

	assign bus.tgt_sda_out = 1'b0;
	assign bus.tgt_sda_oe  = sda_oe;
endmodule // amp_i2c_target

//--- logic/amp_i2c_controller.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "amp_i2c_params.svh"
module amp_i2c_controller #(
	parameter int QUARTER_CYC = `SCL_QUARTER_CYC // Cycles per scl quarter
) (
	input  wire logic        mclk,    // System clock
	input  wire logic        rst,     // Async reset, high
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB direction
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic      [31:0] prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr, // APB error, unmapped
	output logic             irq,     // Level interrupt
	amp_i2c_if.controller    bus      // Serial bus
);
	import amp_i2c_pkg::*;

	if (QUARTER_CYC < 8 || QUARTER_CYC > 65535) begin : g_bad_quarter
		$error("QUARTER_CYC out of range");
	end

	logic [1:0]  sda_s;
	logic        sda_in;
	logic [7:0]  cmd_index;
	logic [1:0]  cmd_len;
	logic        cmd_read;
	logic [1:0]  target_sel;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic        go;
	logic        busy;
	logic        done_set;
	logic        nack_set;
	logic        access;
	logic        wr_now;
	logic        mapped;
	logic [31:0] rd_val;
	logic [15:0] qcnt;
	logic        tick;
	logic [1:0]  q;
	ctl_state_e  state;
	byte_kind_e  kind;
	logic [3:0]  bitn;
	logic [7:0]  shreg;
	logic [1:0]  nbyte;
	logic [1:0]  next_byte;
	logic        ack_bit;
	logic        scl_oe;
	logic        sda_oe;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			sda_s <= 2'h3;
		else
			sda_s <= {sda_s[0], bus.sda};
	end
	assign sda_in = sda_s[1];

	assign access = psel & penable;
	assign wr_now = access & pready & pwrite & mapped;

	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0;
		unique case (paddr)
			`APB_CMD: begin
				rd_val[7:0] = cmd_index;
				rd_val[`CMD_LEN_LSB +: 2] = cmd_len;
				rd_val[`CMD_READ_BIT] = cmd_read;
				rd_val[`CMD_BUSY_BIT] = busy;
			end
			`APB_WDATA:  rd_val = wdata;
			`APB_RDATA:  rd_val = rdata;
			`APB_STATUS: rd_val[1:0] = status;
			`APB_MASK:   rd_val[1:0] = mask;
			`APB_CONFIG: rd_val[1:0] = target_sel;
			default:     mapped = 1'b0;
		endcase
	end

	// One wait state; ready and data leave flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= access & !pready;
			pslverr <= access & !pready & !mapped;
			prdata  <= (access & !pready & !pwrite) ? rd_val : 32'h0;
		end
	end

	// A go while busy is dropped; the command fields stay unchanged
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_index  <= 8'h00;
			cmd_len    <= 2'h0;
			cmd_read   <= 1'b0;
			target_sel <= 2'h0;
			wdata      <= 32'h0;
			mask       <= 2'h0;
			go         <= 1'b0;
		end else begin
			go <= 1'b0;
			if (wr_now && paddr == `APB_CMD && !busy) begin
				cmd_index <= pwdata[7:0];
				cmd_len   <= pwdata[`CMD_LEN_LSB +: 2];
				cmd_read  <= pwdata[`CMD_READ_BIT];
				go        <= pwdata[`CMD_GO_BIT];
			end
			if (wr_now && paddr == `APB_WDATA)
				wdata <= pwdata;
			if (wr_now && paddr == `APB_MASK)
				mask <= pwdata[1:0];
			if (wr_now && paddr == `APB_CONFIG)
				target_sel <= pwdata[1:0];
		end
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status <= 2'h0;
			irq    <= 1'b0;
		end else begin
			status <= (status & ~((wr_now && paddr == `APB_STATUS)
				? pwdata[1:0] : 2'h0)) | {nack_set, done_set};
			irq <= |(status & mask);
		end
	end

	assign tick = busy && (qcnt == 16'(QUARTER_CYC - 1));
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			qcnt <= 16'h0;
		else if (!busy || tick)
			qcnt <= 16'h0;
		else
			qcnt <= qcnt + 16'h1;
	end

	assign next_byte = nbyte + 2'h1;

	// Each bit takes four quarters; sda moves only while scl is low, except to make start and stop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state    <= C_IDLE;
			kind     <= K_ADDRW;
			busy     <= 1'b0;
			q        <= 2'h0;
			bitn     <= 4'h0;
			shreg    <= 8'h00;
			nbyte    <= 2'h0;
			ack_bit  <= 1'b0;
			scl_oe   <= 1'b0;
			sda_oe   <= 1'b0;
			rdata    <= 32'h0;
			done_set <= 1'b0;
			nack_set <= 1'b0;
		end else begin
			done_set <= 1'b0;
			nack_set <= 1'b0;
			if (state == C_IDLE) begin
				if (go) begin
					busy  <= 1'b1;
					kind  <= K_ADDRW;
					q     <= 2'h0;
					state <= C_START;
				end
			end else if (tick) begin
				q <= q + 2'h1;
				unique case (state)
					C_START: unique case (q)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b1;
						2'h3: begin
							scl_oe <= 1'b1;
							shreg  <= {`ADDR_FIXED, target_sel,
								kind == K_ADDRR};
							bitn   <= 4'h0;
							state  <= C_SEND;
						end
					endcase
					C_SEND: unique case (q)
						2'h0: sda_oe <= !shreg[7];
						2'h1: scl_oe <= 1'b0;
						2'h2: ;
						2'h3: begin
							scl_oe <= 1'b1;
							shreg  <= {shreg[6:0], 1'b1};
							bitn   <= bitn + 4'h1;
							if (bitn == 4'h7)
								state <= C_GETACK;
						end
					endcase
					C_GETACK: unique case (q)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: ack_bit <= sda_in;
						2'h3: begin
							scl_oe <= 1'b1;
							bitn   <= 4'h0;
							if (ack_bit) begin
								nack_set <= 1'b1;
								state    <= C_STOP;
							end else begin
								unique case (kind)
									K_ADDRW: begin
										shreg <= cmd_index;
										kind  <= K_INDEX;
										state <= C_SEND;
									end
									K_INDEX: if (cmd_read) begin
										kind  <= K_ADDRR;
										state <= C_START;
									end else begin
										shreg <= wdata[7:0];
										nbyte <= 2'h0;
										kind  <= K_WDATA;
										state <= C_SEND;
									end
									K_WDATA: if (nbyte == cmd_len) begin
										state <= C_STOP;
									end else begin
										nbyte <= next_byte;
										shreg <= wdata[{next_byte, 3'h0} +: 8];
										state <= C_SEND;
									end
									K_ADDRR: begin
										nbyte <= 2'h0;
										state <= C_RECV;
									end
								endcase
							end
						end
					endcase
					C_RECV: unique case (q)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: shreg <= {shreg[6:0], sda_in};
						2'h3: begin
							scl_oe <= 1'b1;
							bitn   <= bitn + 4'h1;
							if (bitn == 4'h7)
								state <= C_PUTACK;
						end
					endcase
					C_PUTACK: unique case (q)
						2'h0: begin
							sda_oe <= (nbyte != cmd_len);
							rdata[{nbyte, 3'h0} +: 8] <= shreg;
						end
						2'h1: scl_oe <= 1'b0;
						2'h2: ;
						2'h3: begin
							scl_oe <= 1'b1;
							bitn   <= 4'h0;
							if (nbyte == cmd_len) begin
								state <= C_STOP;
							end else begin
								nbyte <= next_byte;
								state <= C_RECV;
							end
						end
					endcase
					C_STOP: unique case (q)
						2'h0: sda_oe <= 1'b1;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b0;
						2'h3: begin
							busy     <= 1'b0;
							done_set <= 1'b1;
							state    <= C_IDLE;
						end
					endcase
					C_IDLE: ;
				endcase
			end
		end
	end

	assign bus.ctl_scl_out = 1'b0;
	assign bus.ctl_scl_oe  = scl_oe;
	assign bus.ctl_sda_out = 1'b0;
	assign bus.ctl_sda_oe  = sda_oe;
endmodule // amp_i2c_controller

//--- sim/amp_i2c_chk.sv
`timescale 1ns/1ns
module amp_i2c_chk (
	input wire logic mclk,        // Clock
	input wire logic rst,         // Reset
	input wire logic ctl_scl_out, // Ctl scl
	input wire logic ctl_scl_oe,  // Ctl scl oe
	input wire logic ctl_sda_out, // Ctl sda
	input wire logic ctl_sda_oe,  // Ctl sda oe
	input wire logic tgt_sda_out, // Tgt sda
	input wire logic tgt_sda_oe,  // Tgt sda oe
	input wire logic scl,         // Wire scl
	input wire logic sda          // Wire sda
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence start_seq;
		scl && $fell(sda);
	endsequence
	sequence stop_seq;
		scl && $rose(sda);
	endsequence
	chk_start_then_low: assert property (start_seq |-> ##[1:20] !scl)
		else $error("no scl fall after start");
	chk_stop_idle: assert property (stop_seq |-> scl [*4])
		else $error("scl fell after stop");
	// Target may only move sda while scl is low
	chk_tgt_scl_low: assert property ($changed(tgt_sda_oe) |-> !scl)
		else $error("target moved sda with scl high");
	chk_sda_by_ctl: assert property (
		scl && $past(scl) && $changed(sda) |-> $changed(ctl_sda_oe))
		else $error("sda edge with scl high not from controller");
	chk_scl_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("scl high too short");
	chk_scl_low_len: assert property ($fell(scl) |-> !scl [*3])
		else $error("scl low too short");
	// Target stays off the bus for eight cycles after a stop
	chk_quiet_stop: assert property (stop_seq |-> !tgt_sda_oe [*8])
		else $error("target drives sda after stop");
	// A target pulling sda with scl high would fake a start
	chk_start_by_ctl: assert property (start_seq |->
		ctl_sda_oe && !tgt_sda_oe)
		else $error("start not made by controller");
	chk_idle_rst: assert property ($fell(rst) |-> scl && sda)
		else $error("bus not released after reset");
endmodule // amp_i2c_chk

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, irq, oscillator_primary_role, last_err;
	logic        standby_n = 1'b1;
	logic [1:0]  addr_sel = 2'h0, mask_v = 2'h0;
	logic [3:0]  dc_offset_events = 4'h0, overcurrent_events = 4'h0;
	logic [7:0]  global_events = 8'h00;
	logic [15:0] load_diag_events = 16'h0;
	logic [7:0]  temp_voltage_status = 8'h14, highz_lowlow_status = 8'h25;
	logic [7:0]  mute_play_status = 8'h36, load_diag_status = 8'h47;
	logic [7:0]  thermal_shutdown_foldback_status = 8'h58;
	logic [7:0]  gain_select_ctrl, overcurrent_ctrl, switch_freq_clip_ctrl;
	logic [7:0]  diag_master_mode_ctrl, output_state_ctrl_a;
	logic [7:0]  output_state_ctrl_b, dc_detect_threshold_ctrl;
	int          error_cnt = 0, checks_done = 0;

	amp_i2c_if bus ();
	amp_i2c_target amp_i2c_target_i (
		.mclk(mclk), .rst(rst), .standby_n(standby_n),
		.addr_sel(addr_sel), .bus(bus), .global_events(global_events),
		.dc_offset_events(dc_offset_events),
		.overcurrent_events(overcurrent_events),
		.load_diag_events(load_diag_events),
		.temp_voltage_status(temp_voltage_status),
		.highz_lowlow_status(highz_lowlow_status),
		.mute_play_status(mute_play_status),
		.load_diag_status(load_diag_status),
		.thermal_shutdown_foldback_status(thermal_shutdown_foldback_status),
		.gain_select_ctrl(gain_select_ctrl),
		.overcurrent_ctrl(overcurrent_ctrl),
		.switch_freq_clip_ctrl(switch_freq_clip_ctrl),
		.diag_master_mode_ctrl(diag_master_mode_ctrl),
		.output_state_ctrl_a(output_state_ctrl_a),
		.output_state_ctrl_b(output_state_ctrl_b),
		.dc_detect_threshold_ctrl(dc_detect_threshold_ctrl),
		.oscillator_primary_role(oscillator_primary_role)
	);
	amp_i2c_controller #(.QUARTER_CYC(8)) amp_i2c_controller_i (
		.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .bus(bus)
	);
	amp_i2c_chk amp_i2c_chk_i (
		.mclk(mclk), .rst(rst),
		.ctl_scl_out(bus.ctl_scl_out), .ctl_scl_oe(bus.ctl_scl_oe),
		.ctl_sda_out(bus.ctl_sda_out), .ctl_sda_oe(bus.ctl_sda_oe),
		.tgt_sda_out(bus.tgt_sda_out), .tgt_sda_oe(bus.tgt_sda_oe),
		.scl(bus.scl), .sda(bus.sda)
	);

	always #4 mclk = ~mclk;

	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		q = prdata;
		last_err = pslverr;
		if (pready !== 1'b1) begin
			error_cnt++;
			end_sim();
		end
	endtask

	// Reads compare only the bytes asked for; the rest of the word is stale
	task automatic xfer(input logic rd, input logic [7:0] idx,
			input int nb, input logic [31:0] v, input logic nk);
		int n = 0;
		if (!rd)
			apb(1'b1, 8'h04, v);
		apb(1'b1, 8'h00, {15'h0, 1'b1, 3'h0, rd, 2'h0, 2'(nb - 1), idx});
		do begin
			apb(1'b0, 8'h0c, 32'h0);
			n++;
		end while (q[0] !== 1'b1 && n < 2000);
		chk(q[1:0], {nk, 1'b1});
		if (q[0] !== 1'b1)
			end_sim();
		chk(irq, |(q[1:0] & mask_v));
		apb(1'b1, 8'h0c, 32'h3);
		if (rd && !nk) begin
			apb(1'b0, 8'h08, 32'h0);
			chk(q & (32'hffffffff >> (32 - 8 * nb)), v);
		end
	endtask

	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		apb(1'b0, 8'h20, 32'h0);
		chk(last_err, 1'b1);
		chk(q, 32'h0);
		xfer(1'b1, 8'h00, 2, 32'h0, 1'b0);
		xfer(1'b0, 8'h08, 4, 32'h44332211, 1'b0);
		chk({diag_master_mode_ctrl, switch_freq_clip_ctrl}, 16'h4433);
		chk({overcurrent_ctrl, gain_select_ctrl}, 16'h2211);
		xfer(1'b1, 8'h08, 4, 32'h44332211, 1'b0);
		xfer(1'b0, 8'h0d, 4, 32'h99887766, 1'b0);
		chk({dc_detect_threshold_ctrl, output_state_ctrl_b}, 16'h9966);
		xfer(1'b1, 8'h0d, 4, 32'h99000066, 1'b0);
		xfer(1'b0, 8'h00, 1, 32'hff, 1'b0);
		global_events <= 8'h83;
		overcurrent_events <= 4'h8;
		load_diag_events <= 16'ha55a;
		@(posedge mclk);
		global_events <= 8'h10;
		overcurrent_events <= 4'h0;
		dc_offset_events <= 4'h4;
		load_diag_events <= 16'h0;
		@(posedge mclk);
		global_events <= 8'h00;
		dc_offset_events <= 4'h0;
		xfer(1'b1, 8'h00, 4, 32'ha55a4897, 1'b0);
		xfer(1'b1, 8'h01, 1, 32'h48, 1'b0);
		xfer(1'b1, 8'h04, 4, 32'h47362514, 1'b0);
		xfer(1'b1, 8'h13, 1, 32'h58, 1'b0);
		for (int s = 0; s < 4; s++) begin
			addr_sel <= 2'(s);
			apb(1'b1, 8'h14, 32'(s));
			// Strap passes a synchroniser first
			repeat (5) @(posedge mclk);
			chk(oscillator_primary_role, 32'(s == 0));
			xfer(1'b1, 8'h08, 1, 32'h11, 1'b0);
		end
		mask_v = 2'h3;
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h14, 32'h1);
		xfer(1'b0, 8'h08, 1, 32'hee, 1'b1);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		chk(gain_select_ctrl, 8'h11);
		standby_n <= 1'b0;
		repeat (5) @(posedge mclk);
		chk(gain_select_ctrl, 8'h00);
		standby_n <= 1'b1;
		repeat (4) @(posedge mclk);
		apb(1'b1, 8'h14, 32'h3);
		xfer(1'b1, 8'h00, 2, 32'h0, 1'b0);
		end_sim();
	end
endmodule // tb_top
